// *** rtl/pfm_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfm_core
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // Program memory
    input  wire logic [15:0] i_instr_word,
    output logic      [20:0] o_fetch_addr,
    // Latch access from software
    input  wire logic        i_high_latch_we,
    input  wire logic        i_upper_latch_we,
    input  wire logic [7:0]  i_latch_wdata,
    // Observed state
    output logic      [7:0]  o_pc_low_byte,
    output logic      [7:0]  o_pc_high_latch,
    output logic      [4:0]  o_pc_upper_latch,
    output logic      [7:0]  o_working_register,
    output logic      [7:0]  o_product_high,
    output logic      [7:0]  o_product_low,
    output logic      [4:0]  o_status_flags,
    output logic      [1:0]  o_phase,
    output logic             o_phase_one,
    output logic             o_phase_four
);
    // ====================================================================
    // State
    logic [1:0]  phase_reg;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic [7:0]  high_latch_reg;
    logic [4:0]  upper_latch_reg;
    logic [15:0] ir_reg;
    logic [7:0]  working_register_reg;
    logic [4:0]  flags_reg;
    logic [15:0] prod_reg;
    logic        ph_one;
    logic        ph_four;
    logic        ph_end;
    pfm_pkg::pfm_op_e op;
    logic [7:0]  lit;
    logic [7:0]  alu_sum;
    logic [4:0]  alu_flags;
    logic [15:0] alu_prod;

    // ====================================================================
    // Quadrature phase counter, free running
    // It never pauses, even with nothing to fetch, so the phases cannot slip
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            phase_reg <= pfm_pkg::PH_ONE;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // Results of execution land on the edge that closes the cycle
    assign ph_one  = (phase_reg == pfm_pkg::PH_ONE);
    assign ph_four = (phase_reg == pfm_pkg::PH_FOUR);
    assign ph_end  = ph_four;

    // ====================================================================
    // Decode of the word latched at the end of the previous cycle
    // Opcodes 6 and 7 match no operation and behave as no-ops
    assign op  = pfm_pkg::pfm_op_e'(ir_reg[15:pfm_pkg::OP_LSB]);
    assign lit = ir_reg[7:0];

    // Adder and multiplier share operands: working register and literal
    pfm_alu u_alu
    (
        .i_a       (working_register_reg),
        .i_b       (lit),
        .o_sum     (alu_sum),
        .o_flags   (alu_flags),
        .o_product (alu_prod)
    );

    // ====================================================================
    // Next program counter. A jump or a low-byte write takes effect at the
    // edge that ends phase four; the phase-one step of the following cycle
    // then advances past the target, so the first word fetched after a
    // change of flow sits two bytes above the target address.
    // The jump field is 13 bits wide, so a jump reaches the first 16 Kbytes only.
    always_comb
    begin
        pc_next = pc_reg;
        if (ph_end && op == pfm_pkg::PFM_OP_JUMP)
            pc_next = {8'h00, ir_reg[12:0]} << 1;
        else if (ph_end && op == pfm_pkg::PFM_OP_WR_LOW)
            pc_next = {upper_latch_reg, high_latch_reg, lit};
        else if (ph_one)
            pc_next = pc_reg + 21'(pfm_pkg::PC_STEP);
        pc_next[0] = 1'b0;
    end

    // Program counter; only changes through the paths above
    // Bit 0 is forced low in the next-value logic, so it is never stored high
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            pc_reg <= pfm_pkg::PC_RESET;
        else
            pc_reg <= pc_next;
    end

    // ====================================================================
    // Latches: software writes, or a low-byte read snapshots the counter.
    // A low-byte read wins over a software write in the same cycle.
    // The latches feed the counter only through a low-byte write.
    // Software sees a snapshot one clock later on the output port.
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            high_latch_reg  <= pfm_pkg::LATCH_RESET;
            upper_latch_reg <= pfm_pkg::UPPER_RESET;
        end
        else if (ph_end && op == pfm_pkg::PFM_OP_RD_LOW)
        begin
            high_latch_reg  <= pc_reg[15:8];
            upper_latch_reg <= pc_reg[20:16];
        end
        else
        begin
            if (i_high_latch_we)
                high_latch_reg <= i_latch_wdata;
            if (i_upper_latch_we)
                upper_latch_reg <= i_latch_wdata[4:0];
        end
    end

    // ====================================================================
    // Fetch: the word addressed in this cycle is taken at the edge ending
    // phase four and decoded straight from this register in the next cycle,
    // which keeps execution exactly one cycle behind the fetch.
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ir_reg <= pfm_pkg::WORD_RESET;
        else if (ph_four)
            ir_reg <= i_instr_word;
    end

    // ====================================================================
    // Working register, flags and product, written at end of execute cycle
    // Multiply touches only the product pair, so the flags keep their value
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            working_register_reg  <= pfm_pkg::BYTE_RESET;
            flags_reg <= pfm_pkg::FLAGS_RESET;
            prod_reg  <= pfm_pkg::WORD_RESET;
        end
        else if (ph_end)
        begin
            if (op == pfm_pkg::PFM_OP_ADD_LIT)
            begin
                working_register_reg  <= alu_sum;
                flags_reg <= alu_flags;
            end
            else if (op == pfm_pkg::PFM_OP_MUL_LIT)
                prod_reg <= alu_prod;
        end
    end

    // ====================================================================
    // Registered outputs
    // Latch, working register, flag and product outputs lag the state by one clock; counter outputs come from pc_next, and the phase flags are computed
    // from the phase about to be entered so that they line up with o_phase.
    // Phase one flag leaves reset set, since the counter restarts in phase one.
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_fetch_addr       <= pfm_pkg::PC_RESET;
            o_pc_low_byte      <= pfm_pkg::BYTE_RESET;
            o_pc_high_latch    <= pfm_pkg::LATCH_RESET;
            o_pc_upper_latch   <= pfm_pkg::UPPER_RESET;
            o_working_register <= pfm_pkg::BYTE_RESET;
            o_product_high     <= pfm_pkg::BYTE_RESET;
            o_product_low      <= pfm_pkg::BYTE_RESET;
            o_status_flags     <= pfm_pkg::FLAGS_RESET;
            o_phase            <= pfm_pkg::PH_ONE;
            o_phase_one        <= 1'b1;
            o_phase_four       <= 1'b0;
        end
        else
        begin
            o_fetch_addr       <= pc_next;
            o_pc_low_byte      <= pc_next[7:0];
            o_pc_high_latch    <= high_latch_reg;
            o_pc_upper_latch   <= upper_latch_reg;
            o_working_register <= working_register_reg;
            o_product_high     <= prod_reg[15:8];
            o_product_low      <= prod_reg[7:0];
            o_status_flags     <= flags_reg;
            o_phase            <= phase_reg + 2'h1;
            o_phase_one        <= (phase_reg == pfm_pkg::PH_FOUR);
            o_phase_four       <= (phase_reg == 2'h2);
        end
    end
endmodule // pfm_core
`default_nettype wire

// *** rtl/pfm_pkg.sv ***
`default_nettype none
package pfm_pkg;
    // ====================================================================
    // Program counter geometry
    localparam int unsigned PC_WIDTH    = 21;
    localparam int unsigned PC_STEP     = 2;
    localparam logic [20:0] PC_RESET    = 21'h000000;
    localparam logic [7:0]  LATCH_RESET = 8'h00;
    localparam logic [4:0]  UPPER_RESET = 5'h00;
    localparam int unsigned HIGH_LSB    = 8;
    localparam int unsigned UPPER_LSB   = 16;
    // ====================================================================
    // Quadrature phase divider
    localparam int unsigned PHASE_COUNT = 4;
    localparam logic [1:0]  PH_ONE      = 2'h0;
    localparam logic [1:0]  PH_FOUR     = 2'h3;
    // ====================================================================
    // Status flag positions
    localparam int unsigned FLG_C  = 0;
    localparam int unsigned FLG_DC = 1;
    localparam int unsigned FLG_Z  = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_N  = 4;
    localparam logic [4:0]  FLAGS_RESET = 5'h00;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    // ====================================================================
    // Execute operations decoded from the instruction register
    typedef enum logic [2:0] {
        PFM_OP_NOP,
        PFM_OP_ADD_LIT,
        PFM_OP_MUL_LIT,
        PFM_OP_JUMP,
        PFM_OP_WR_LOW,
        PFM_OP_RD_LOW
    } pfm_op_e;
    // Instruction word field layout: [15:13] op, [7:0] literal
    localparam int unsigned OP_LSB = 13;
endpackage
`default_nettype wire

// *** rtl/pfm_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// Adder with flags and 8x8 unsigned multiplier, purely combinational
module pfm_alu
(
    // Operands
    input  wire logic [7:0]  i_a,
    input  wire logic [7:0]  i_b,
    // Results
    output logic      [7:0]  o_sum,
    output logic      [4:0]  o_flags,
    output logic      [15:0] o_product
);
    logic [8:0] full_sum;
    logic [4:0] nib_sum;

    // Sum and carries
    always_comb
    begin
        full_sum = {1'b0, i_a} + {1'b0, i_b};
        nib_sum  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        o_sum    = full_sum[7:0];
        o_flags  = pfm_pkg::FLAGS_RESET;
        o_flags[pfm_pkg::FLG_C]  = full_sum[8];
        o_flags[pfm_pkg::FLG_DC] = nib_sum[4];
        o_flags[pfm_pkg::FLG_Z]  = (full_sum[7:0] == 8'h00);
        o_flags[pfm_pkg::FLG_OV] = (i_a[7] == i_b[7]) && (full_sum[7] != i_a[7]);
        o_flags[pfm_pkg::FLG_N]  = full_sum[7];
    end

    // Unsigned product, one cycle
    assign o_product = {8'h00, i_a} * {8'h00, i_b};
endmodule // pfm_alu
`default_nettype wire

// *** dv/pfm_prog_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Program memory model: combinational word lookup
module pfm_prog_mem
(
    // Fetch port
    input  wire logic [20:0] i_addr,
    output logic      [15:0] o_word
);
    logic [15:0] mem [64];
    // Table wraps, so any computed target still finds a defined word
    assign o_word = mem[i_addr[6:1]];
endmodule // pfm_prog_mem
`default_nettype wire

// *** dv/pfm_core_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Port checker for the core sequencing slice
module pfm_core_checker
(
    // Watched ports
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_high_latch_we,
    input wire logic        i_upper_latch_we,
    input wire logic [7:0]  i_latch_wdata,
    input wire logic [20:0] o_fetch_addr,
    input wire logic [7:0]  o_pc_low_byte,
    input wire logic [7:0]  o_pc_high_latch,
    input wire logic [4:0]  o_pc_upper_latch,
    input wire logic [1:0]  o_phase,
    input wire logic        o_phase_one,
    input wire logic        o_phase_four
);
    default clocking cb @(posedge i_mclk); endclocking
    // Reset release seen one edge late: the releasing edge still finds the
    // design in reset, so attempts starting on it are skipped
    logic rst_q;
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rst_q <= 1'b1;
        else
            rst_q <= 1'b0;
    end
    default disable iff (i_sys_rst || rst_q);
    // Four phases in order, then back to phase one
    sequence s_quad;
        o_phase == 2'h0 ##1 o_phase == 2'h1 ##1 o_phase == 2'h2 ##1 o_phase == 2'h3;
    endsequence
    property p_quad; o_phase_one |-> s_quad ##1 o_phase_one; endproperty
    a_quad: assert property (p_quad) else $error("phase sequence broken");
    property p_step; o_phase != 2'h3 |=> o_phase == $past(o_phase) + 2'h1; endproperty
    a_step: assert property (p_step) else $error("phase did not advance");
    property p_one; o_phase_one == (o_phase == pfm_pkg::PH_ONE); endproperty
    a_one: assert property (p_one) else $error("phase one flag wrong");
    property p_four; o_phase_four == (o_phase == pfm_pkg::PH_FOUR); endproperty
    a_four: assert property (p_four) else $error("phase four flag wrong");
    property p_align; !o_fetch_addr[0] && !o_pc_low_byte[0]; endproperty
    a_align: assert property (p_align) else $error("counter misaligned");
    property p_low; o_pc_low_byte == o_fetch_addr[7:0]; endproperty
    a_low: assert property (p_low) else $error("low byte differs from counter");
    // Snapshot edge excluded: it wins over a software write; the port lags the latch by one clock
    property p_hwr;
        i_high_latch_we && o_phase != 2'h3 |=> ##1 o_pc_high_latch == $past(i_latch_wdata, 2);
    endproperty
    a_hwr: assert property (p_hwr) else $error("high latch write lost");
    property p_uwr;
        i_upper_latch_we && o_phase != 2'h3 |=> ##1 o_pc_upper_latch == $past(i_latch_wdata[4:0], 2);
    endproperty
    a_uwr: assert property (p_uwr) else $error("upper latch write lost");
    property p_rst;
        $fell(i_sys_rst) |-> o_fetch_addr == 21'h0 && {o_pc_upper_latch, o_pc_high_latch} == 13'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule // pfm_core_checker
bind pfm_core pfm_core_checker chk_u (.i_mclk, .i_sys_rst, .i_high_latch_we, .i_upper_latch_we, .i_latch_wdata,
    .o_fetch_addr, .o_pc_low_byte, .o_pc_high_latch, .o_pc_upper_latch, .o_phase, .o_phase_one, .o_phase_four);
`default_nettype wire

// *** dv/pc_fetch_and_multiply_core_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module pc_fetch_and_multiply_core_tb;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_high_latch_we = 1'b0;
    logic        i_upper_latch_we = 1'b0;
    logic [7:0]  i_latch_wdata = 8'h00;
    logic [15:0] i_instr_word;
    logic [20:0] o_fetch_addr, m_pc;
    logic [7:0]  o_pc_low_byte, o_pc_high_latch, o_working_register, o_product_high, o_product_low, m_w, m_hl;
    logic [4:0]  o_pc_upper_latch, o_status_flags, m_ul, m_fl;
    logic [15:0] m_ir, m_prod;
    logic [1:0]  o_phase;
    logic        o_phase_one, o_phase_four;
    int          n_mismatch = 0;
    int          total_checks = 0;
    // Corners: carries, overflow, a full-scale product, a low-byte read and write
    logic [15:0] corner [9] = '{16'h2010, 16'h2015, 16'h20da, 16'h40ff, 16'h2001,
                                16'h207f, 16'h2001, 16'ha000, 16'h8041};
    // ====
    // Clock, design and program memory
    always #25 i_mclk = ~i_mclk;
    pfm_core dut_u (.i_mclk, .i_sys_rst, .i_instr_word, .o_fetch_addr, .i_high_latch_we, .i_upper_latch_we,
        .i_latch_wdata, .o_pc_low_byte, .o_pc_high_latch, .o_pc_upper_latch, .o_working_register,
        .o_product_high, .o_product_low, .o_status_flags, .o_phase, .o_phase_one, .o_phase_four);
    pfm_prog_mem mem_u (.i_addr(o_fetch_addr), .o_word(i_instr_word));
    // ====
    // Comparison, verdict and bounded waits
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_phase(input logic [1:0] ph);
        for (int k = 0; k < 8 && o_phase !== ph; k++)
            @(negedge i_mclk);
        if (o_phase !== ph)
        begin
            n_mismatch++;
            summarize();
        end
    endtask
    // Sum plus {N,OV,Z,DC,C}
    function automatic logic [12:0] add_res(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b;
        h = a[3:0] + b[3:0];
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction
    // ====
    // Reset and one instruction cycle against the reference
    task automatic do_reset();
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (12) @(posedge i_mclk);
        check("reset_pc", o_fetch_addr, 32'h0);
        check("reset_latch", {o_pc_upper_latch, o_pc_high_latch}, 32'h0);
        i_sys_rst <= 1'b0;
        {m_pc, m_ir, m_w, m_hl, m_ul, m_fl, m_prod} = '0;
    endtask
    task automatic cycle_step();
        logic [7:0] d;
        logic [1:0] we;
        logic [15:0] nx;
        m_pc = m_pc + 21'h2;
        wait_phase(2'h1);
        d = 8'($urandom);
        we = 2'($urandom);
        @(posedge i_mclk);
        {i_upper_latch_we, i_high_latch_we} <= we;
        i_latch_wdata <= d;
        @(posedge i_mclk);
        {i_upper_latch_we, i_high_latch_we} <= 2'h0;
        @(negedge i_mclk);
        check("phase", {o_phase_one, o_phase_four, o_phase}, 32'h7);
        check("fetch_addr", o_fetch_addr, m_pc);
        check("pc_low", o_pc_low_byte, m_pc[7:0]);
        check("latches", {o_pc_upper_latch, o_pc_high_latch}, {m_ul, m_hl});
        check("working_register_flags", {o_status_flags, o_working_register}, {m_fl, m_w});
        check("product", {o_product_high, o_product_low}, m_prod);
        if (we[0]) m_hl = d;
        if (we[1]) m_ul = d[4:0];
        // The word latched this cycle comes from the counter before any change of flow
        nx = mem_u.mem[m_pc[6:1]];
        case (m_ir[15:13])
            3'h1: {m_fl, m_w} = add_res(m_w, m_ir[7:0]);
            3'h2: m_prod = m_w * m_ir[7:0];
            3'h3: m_pc = {7'h00, m_ir[12:0], 1'b0};
            3'h4: m_pc = {m_ul, m_hl, m_ir[7:1], 1'b0};
            3'h5: {m_ul, m_hl} = {m_pc[20:16], m_pc[15:8]};
            default: ;
        endcase
        m_ir = nx;
    endtask
    // ====
    // Random program led by hand-written carry, overflow and product corners
    initial
    begin
        void'($urandom(49191));
        for (int i = 0; i < 64; i++)
            mem_u.mem[i] = {3'($urandom_range(0, 5)), 13'($urandom)};
        for (int i = 0; i < 9; i++)
            mem_u.mem[i + 1] = corner[i];
        do_reset();
        repeat (150) cycle_step();
        repeat ($urandom_range(0, 3)) @(posedge i_mclk);
        do_reset();
        repeat (150) cycle_step();
        summarize();
    end
endmodule // pc_fetch_and_multiply_core_tb
`default_nettype wire
